// ==== hdl/wake_ctrl_pkg.sv ====
/*
 power management unit wake-up control: register addresses, field positions, reset values and timing counts.
 assumes an 8-bit special function register port with an sfr page select, as used by the core.
 // Function
 // - write one to bit 7 enters sleep
 // - write one to bit 6 enters suspend
 // - write one to bit 5 clears flags
 // - bit 4 reads reset pin glitch flag
 // - bit 3 enables oscillator fail, reads flag
 // - bit 2 enables alarm wake, reads flag
 // - bit 1 enables port match, reads flag
 // - bit 0 enables comparator edge, reads flag
 // - any flag set blocks low-power entry
 // - flags read zero two clocks after suspend
 // - extension bit 0 cap sense, rest zero
 // - mode bit 7 drives rtc clock out
 // - mode bit 6 enables wake request out
 // - mode bit 5 disables supply monitor
 // - mode bits 4:0 read zero
 // - wake request driven low leaving sleep
 // - flags always set by their events
 // - reset with monitor off is full reset
 // - reset pin edge always wakes sleep
*/
package wake_ctrl_pkg;
	localparam logic [7:0] CFG_ADDR        = 8'hB5;
	localparam logic [7:0] MODE_ADDR       = 8'hB5;
	localparam logic [7:0] EXT_ADDR        = 8'hCE;
	localparam logic [3:0] CFG_PAGE        = 4'h0;
	localparam logic [3:0] MODE_PAGE       = 4'hF;
	localparam int         SLEEP_BIT       = 7;
	localparam int         SUSPEND_BIT     = 6;
	localparam int         CLEAR_BIT       = 5;
	localparam int         RSTWAKE_BIT     = 4;
	localparam int         RTC_OUT_BIT     = 7;
	localparam int         WAKE_OUT_BIT    = 6;
	localparam int         MON_DIS_BIT     = 5;
	localparam int         NUM_SRC         = 5;
	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam logic [4:0] ENABLE_RESET    = 5'h00;
	localparam int         CLK_MHZ         = 50;
	localparam int         SUSP_HOLD_CLK   = 2;
	localparam logic [1:0] SUSP_HOLD_CNT   = 2'(SUSP_HOLD_CLK);
	typedef enum logic [1:0] {ST_RUN, ST_SUSPEND, ST_SLEEP} pmu_state_t;
endpackage : wake_ctrl_pkg

// ==== hdl/wake_flag_cell.sv ====
/*
 one wake-up flag with its enable bit.
 assumes event pulses already in the clk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_flag_cell
	import wake_ctrl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic ce_i,
	input  wire logic event_i,
	input  wire logic clear_i,
	input  wire logic en_we_i,
	input  wire logic en_wd_i,
	output logic      flag_o,
	output logic      enable_o
);
	logic flag_next;
	assign flag_next = event_i | (flag_o & ~clear_i);
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			flag_o   <= 1'b0;
			enable_o <= 1'b0;
		end
		else if (ce_i)
		begin
			flag_o <= flag_next;
			if (en_we_i)
				enable_o <= en_wd_i;
		end
	end
endmodule : wake_flag_cell
`default_nettype wire

// ==== hdl/low_power_wakeup_control.sv ====
/*
 wake-up control: low-power mode select, wake sources, flags, rtc clock out, wake request out, monitor disable.
 assumes the core sfr port on clk_i; wake sources arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module low_power_wakeup_control
	import wake_ctrl_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [3:0] sfr_page_i,
	input  wire logic       sfr_we_i,
	input  wire logic       sfr_re_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] sfr_rdata_o,
	input  wire logic       rtc_fail_i,
	input  wire logic       rtc_alarm_i,
	input  wire logic       port_match_i,
	input  wire logic       comparator_i,
	input  wire logic       cap_sense_i,
	input  wire logic       reset_pin_n_i,
	input  wire logic       rtc_clock_i,
	input  wire logic       por_reset_i,
	output logic            suspend_o,
	output logic            sleep_o,
	output logic            lp_osc_keep_o,
	output logic            rtc_clock_pin_o,
	output logic            rtc_clock_oe_o,
	output logic            wake_request_pin_o,
	output logic            wake_request_oe_o,
	output logic            supply_monitor_disable_o,
	output logic            full_por_request_o
);
	// src order: 0 comparator, 1 port match, 2 alarm, 3 osc fail, 4 cap sense
	logic [NUM_SRC-1:0] raw_src;
	logic [NUM_SRC-1:0] sync1_reg;
	logic [NUM_SRC-1:0] sync2_reg;
	logic [NUM_SRC-1:0] last_reg;
	logic [NUM_SRC-1:0] src_event;
	logic [NUM_SRC-1:0] flag;
	logic [NUM_SRC-1:0] enable;
	logic [NUM_SRC-1:0] en_we;
	logic [NUM_SRC-1:0] en_wd;
	logic [1:0]         rst_sync_reg;
	logic               rst_last_reg;
	logic               rst_fall;
	logic               rst_flag_reg;
	logic               rst_flag_next;
	logic [1:0]         rtc_sync_reg;
	logic [7:0]         mode_reg;
	logic [7:0]         mode_next;
	pmu_state_t         state_reg;
	pmu_state_t         state_next;
	logic [1:0]         hold_reg;
	logic [1:0]         hold_next;
	logic               wreq_reg;
	logic               cfg_sel;
	logic               mode_sel;
	logic               ext_sel;
	logic               cfg_wr;
	logic               mode_wr;
	logic               ext_wr;
	logic               clear_all;
	logic               any_flag;
	logic               wake_hit;
	logic               enter_sleep;
	logic               enter_suspend;
	logic               flags_hidden;
	logic [7:0]         cfg_read;
	logic [7:0]         ext_read;
	logic [7:0]         rdata_next;

	assign raw_src   = {cap_sense_i, rtc_fail_i, rtc_alarm_i, port_match_i, comparator_i};
	assign cfg_sel   = (sfr_addr_i == CFG_ADDR) && (sfr_page_i == CFG_PAGE);
	assign mode_sel  = (sfr_addr_i == MODE_ADDR) && (sfr_page_i == MODE_PAGE);
	assign ext_sel   = (sfr_addr_i == EXT_ADDR);
	assign cfg_wr    = sfr_we_i & cfg_sel;
	assign mode_wr   = sfr_we_i & mode_sel;
	assign ext_wr    = sfr_we_i & ext_sel;
	assign clear_all = cfg_wr & sfr_wdata_i[CLEAR_BIT];
	// rising edges for the sources, falling edge for the reset pin; the second stage alone feeds the edge logic
	assign src_event = sync2_reg & ~last_reg;
	assign rst_fall  = rst_last_reg & ~rst_sync_reg[1];
	assign en_we     = {ext_wr, {(NUM_SRC-1){cfg_wr}}};
	assign en_wd     = {sfr_wdata_i[0], sfr_wdata_i[3:0]};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_src
			wake_flag_cell u_cell (
				.clk_i    (clk_i),
				.reset_i  (reset_i),
				.ce_i     (ce_i),
				.event_i  (src_event[gi]),
				.clear_i  (clear_all),
				.en_we_i  (en_we[gi]),
				.en_wd_i  (en_wd[gi]),
				.flag_o   (flag[gi]),
				.enable_o (enable[gi])
			);
		end
	endgenerate

	assign rst_flag_next = rst_fall | (rst_flag_reg & ~clear_all);
	assign any_flag      = (|flag) | rst_flag_reg;
	assign wake_hit      = (|(flag & enable)) | rst_flag_reg;
	assign enter_sleep   = cfg_wr & sfr_wdata_i[SLEEP_BIT] & ~any_flag;
	assign enter_suspend = cfg_wr & sfr_wdata_i[SUSPEND_BIT] & ~any_flag & ~sfr_wdata_i[SLEEP_BIT];

	always_comb
	begin
		state_next = state_reg;
		hold_next  = (hold_reg != 2'h0) ? hold_reg - 2'h1 : 2'h0;
		case (state_reg)
			ST_RUN:
			begin
				if (enter_sleep)
					state_next = ST_SLEEP;
				else if (enter_suspend)
					state_next = ST_SUSPEND;
			end
			ST_SUSPEND:
			begin
				if (wake_hit)
				begin
					state_next = ST_RUN;
					hold_next  = SUSP_HOLD_CNT;
				end
			end
			ST_SLEEP:
			begin
				if (wake_hit)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	assign flags_hidden = (hold_reg != 2'h0);
	assign cfg_read  = flags_hidden ? 8'h00 : {3'h0, rst_flag_reg, flag[3:0]};
	assign ext_read  = flags_hidden ? 8'h00 : {7'h00, flag[4]};
	assign mode_next = mode_wr ? {sfr_wdata_i[7:5], 5'h00} : mode_reg;
	assign rdata_next = !sfr_re_i ? sfr_rdata_o :
		mode_sel ? mode_reg :
		cfg_sel ? cfg_read :
		ext_sel ? ext_read : 8'h00;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sync1_reg    <= 5'h00;
			sync2_reg    <= 5'h00;
			last_reg     <= 5'h00;
			rst_sync_reg <= 2'h3;
			rst_last_reg <= 1'b1;
			rtc_sync_reg <= 2'h0;
		end
		else if (ce_i)
		begin
			sync1_reg    <= raw_src;
			sync2_reg    <= sync1_reg;
			last_reg     <= sync2_reg;
			rst_sync_reg <= {rst_sync_reg[0], reset_pin_n_i};
			rst_last_reg <= rst_sync_reg[1];
			rtc_sync_reg <= {rtc_sync_reg[0], rtc_clock_i};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mode_reg     <= MODE_RESET;
			state_reg    <= ST_RUN;
			hold_reg     <= 2'h0;
			rst_flag_reg <= 1'b0;
			wreq_reg     <= 1'b1;
			sfr_rdata_o  <= 8'h00;
		end
		else if (ce_i)
		begin
			mode_reg     <= mode_next;
			state_reg    <= state_next;
			hold_reg     <= hold_next;
			rst_flag_reg <= rst_flag_next;
			sfr_rdata_o  <= rdata_next;
			if (state_reg == ST_SLEEP && state_next == ST_RUN)
				wreq_reg <= 1'b0;
			else if (state_next == ST_SLEEP)
				wreq_reg <= 1'b1;
		end
	end

	assign suspend_o     = (state_reg == ST_SUSPEND);
	assign sleep_o       = (state_reg == ST_SLEEP);
	assign lp_osc_keep_o = any_flag;
	assign rtc_clock_pin_o    = rtc_sync_reg[1] & mode_reg[RTC_OUT_BIT];
	assign rtc_clock_oe_o     = mode_reg[RTC_OUT_BIT];
	assign wake_request_pin_o = wreq_reg;
	assign wake_request_oe_o  = mode_reg[WAKE_OUT_BIT];
	assign supply_monitor_disable_o = mode_reg[MON_DIS_BIT];
	// with monitor disabled, a por or reset pin fall escalates to full reset; reset_i or a mode write with bit 5 low clears the disable
	assign full_por_request_o = mode_reg[MON_DIS_BIT] & (por_reset_i | rst_fall);

	// checks sit inside so they see the flags and state, not only the pins
	chk_sleep_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && enter_sleep |=> sleep_o)
		else $error("sleep not entered");
	chk_suspend_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && enter_suspend |=> suspend_o)
		else $error("suspend not entered");
	chk_clear_flags: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && clear_all && !rst_fall |=> !rst_flag_reg)
		else $error("flag not cleared");
	chk_clear_cells: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && clear_all && src_event == 5'h00 |=> flag == 5'h00)
		else $error("wake flags not cleared");
	chk_pin_flag: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && rst_fall |=> rst_flag_reg)
		else $error("reset pin flag not set");
	chk_reset_values: assert property (@(posedge clk_i)
		reset_i |=> state_reg == ST_RUN && mode_reg == MODE_RESET && enable == ENABLE_RESET)
		else $error("reset values wrong");
	chk_block_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == ST_RUN && any_flag |=> state_reg == ST_RUN)
		else $error("entered with flag");
	chk_refuse_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && state_reg == ST_RUN && cfg_wr && any_flag |=> !sleep_o && !suspend_o)
		else $error("low power write taken with flag");
	chk_hide_flags: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && suspend_o && wake_hit |=> (cfg_read == 8'h00) ##1 (!ce_i || ext_read == 8'h00))
		else $error("flags visible");
	chk_hide_count: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && suspend_o && wake_hit |=> hold_reg == SUSP_HOLD_CNT)
		else $error("hide count not loaded");
	chk_ext_upper: assert property (@(posedge clk_i) disable iff (reset_i)
		ext_read[7:1] == 7'h00)
		else $error("extension upper bits");
	chk_rtc_enable: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && mode_wr |=> rtc_clock_oe_o == $past(sfr_wdata_i[RTC_OUT_BIT]))
		else $error("rtc out enable not written");
	chk_wake_enable: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && mode_wr |=> wake_request_oe_o == $past(sfr_wdata_i[WAKE_OUT_BIT]))
		else $error("wake out enable not written");
	chk_monitor_off: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && mode_wr |=> supply_monitor_disable_o == $past(sfr_wdata_i[MON_DIS_BIT]))
		else $error("monitor disable not written");
	chk_mode_unused: assert property (@(posedge clk_i) disable iff (reset_i)
		mode_reg[4:0] == 5'h00)
		else $error("unused mode bits set");
	chk_mode_read: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && sfr_re_i && mode_sel |=> sfr_rdata_o[4:0] == 5'h00)
		else $error("unused mode bits read");
	chk_wake_req: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && sleep_o && wake_hit |=> !wake_request_pin_o && !sleep_o)
		else $error("no wake request");
	chk_wreq_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && enter_sleep |=> wake_request_pin_o)
		else $error("wake request not raised");
	chk_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && src_event != 5'h00 |=> (flag & $past(src_event)) == $past(src_event))
		else $error("event did not set flag");
	chk_full_por: assert property (@(posedge clk_i) disable iff (reset_i)
		supply_monitor_disable_o && por_reset_i |-> full_por_request_o)
		else $error("no full reset request");
	chk_monitor_reset: assert property (@(posedge clk_i)
		reset_i |=> !supply_monitor_disable_o)
		else $error("monitor not re-enabled");
	chk_pin_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && sleep_o && rst_flag_reg |=> !sleep_o)
		else $error("reset pin did not wake");
	chk_wake_exit: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && (suspend_o || sleep_o) && wake_hit |=> !suspend_o && !sleep_o)
		else $error("no wake");
	// a low enable must freeze read data too, or a stalled core loses it
	chk_ce_freeze: assert property (@(posedge clk_i) disable iff (reset_i)
		!ce_i |=> $stable(state_reg) && $stable(mode_reg) && $stable(flag) && $stable(sfr_rdata_o))
		else $error("state moved with enable low");

	cov_sleep: cover property (@(posedge clk_i) sleep_o ##[1:50] !sleep_o);
	cov_suspend: cover property (@(posedge clk_i) suspend_o ##[1:50] !suspend_o);
	cov_blocked: cover property (@(posedge clk_i) any_flag && cfg_wr && sfr_wdata_i[SLEEP_BIT]);
	cov_pin_wake: cover property (@(posedge clk_i) sleep_o && rst_flag_reg);
	cov_hidden_read: cover property (@(posedge clk_i) ce_i && flags_hidden && sfr_re_i && cfg_sel);
endmodule : low_power_wakeup_control
`default_nettype wire

// ==== bench/wake_source_model.sv ====
/*
 wake event sources: stretches bench kicks into event levels, makes a slow rtc clock.
 assumes kicks arrive on clk_i, one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_source_model
(
	input  wire logic       clk_i,
	input  wire logic [5:0] kick_i,
	output logic      [5:0] level_o,
	output logic            rtc_clock_o
);
	logic [5:0] s1_reg = 6'h00;
	logic [5:0] s2_reg = 6'h00;
	logic [3:0] div_reg = 4'h0;
	// three clocks wide so the two-stage sync cannot miss an edge
	assign level_o = kick_i | s1_reg | s2_reg;
	assign rtc_clock_o = div_reg[3];
	always_ff @(posedge clk_i)
	begin
		s1_reg <= kick_i;
		s2_reg <= s1_reg;
		div_reg <= div_reg + 4'h1;
	end
endmodule : wake_source_model
`default_nettype wire

// ==== bench/test_low_power_wakeup_control.sv ====
/*
 self-checking bench for the wake-up control block.
 assumes wake_source_model beside it; reads are scored through a queue.
*/
`timescale 1ns/1ps
`default_nettype none
module test_low_power_wakeup_control;
	import wake_ctrl_pkg::*;
	logic       clk_i = 1'b0, reset_i = 1'b1, we = 1'b0, re = 1'b0, por = 1'b0, re_seen = 1'b0, ce = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0] page = 4'h0;
	logic [5:0] kick = 6'h00, lvl;
	logic       rtcclk, susp, slp, keep, rco, rcoe, wrp, wroe, mdis, fpor;
	logic [7:0] exp_q[$];
	int         error_cnt = 0, tests_run = 0, seed = 32'h4D08E443;

	wake_source_model wake_source_model_i (.clk_i(clk_i), .kick_i(kick), .level_o(lvl), .rtc_clock_o(rtcclk));
	low_power_wakeup_control low_power_wakeup_control_i (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
		.sfr_addr_i(addr), .sfr_page_i(page), .sfr_we_i(we), .sfr_re_i(re), .sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata), .rtc_fail_i(lvl[3]), .rtc_alarm_i(lvl[2]), .port_match_i(lvl[1]),
		.comparator_i(lvl[0]), .cap_sense_i(lvl[4]), .reset_pin_n_i(~lvl[5]), .rtc_clock_i(rtcclk),
		.por_reset_i(por), .suspend_o(susp), .sleep_o(slp), .lp_osc_keep_o(keep), .rtc_clock_pin_o(rco),
		.rtc_clock_oe_o(rcoe), .wake_request_pin_o(wrp), .wake_request_oe_o(wroe),
		.supply_monitor_disable_o(mdis), .full_por_request_o(fpor));

	initial
		forever #10 clk_i = ~clk_i;

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// read data stands one cycle after the taking edge
	always @(posedge clk_i)
	begin
		if (re_seen === 1'b1)
			chk("sfr_rdata_o", exp_q.pop_front(), rdata);
		re_seen <= re;
	end

	task acc(input logic w, input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		{we, re, addr, page} = {w, ~w, a, p};
		if (w)
			wdata = d;
		else
			exp_q.push_back(d);
		@(posedge clk_i);
		#1;
		{we, re} = 2'b00;
	endtask : acc

	task kick_src(input int b);
		@(posedge clk_i);
		#1 kick[b] = 1'b1;
		@(posedge clk_i);
		#1 kick[b] = 1'b0;
	endtask : kick_src

	task wake_wait;
		repeat (20)
		begin
			@(posedge clk_i);
			#1;
			if (slp === 1'b0 && susp === 1'b0)
				break;
		end
		chk("low power state", 8'h00, {6'h00, slp, susp});
	endtask : wake_wait

	task close_out;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	initial
	begin
		#200000 error_cnt++;
		close_out();
	end

	initial
	begin
		logic [7:0] d, ones;
		repeat (4) @(posedge clk_i);
		#1 reset_i = 1'b0;
		acc(0, MODE_ADDR, MODE_PAGE, MODE_RESET);
		acc(0, CFG_ADDR, CFG_PAGE, 8'h00);
		acc(0, EXT_ADDR, 4'h3, 8'h00);
		chk("wake_request_pin_o", 8'h01, {7'h00, wrp});
		$display("test reset done");
		repeat (4)
		begin
			d = 8'($random(seed));
			acc(1, MODE_ADDR, MODE_PAGE, d);
			chk("mode outputs", {5'h00, d[7:5]}, {5'h00, rcoe, wroe, mdis});
			acc(0, MODE_ADDR, MODE_PAGE, d & 8'hE0);
		end
		ce = 1'b0;
		acc(1, MODE_ADDR, MODE_PAGE, 8'hE0);
		ce = 1'b1;
		chk("frozen mode", {5'h00, d[7:5]}, {5'h00, rcoe, wroe, mdis});
		acc(1, MODE_ADDR, MODE_PAGE, 8'hE0);
		por = 1'b1;
		#1 chk("full_por_request_o", 8'h01, {7'h00, fpor});
		@(posedge clk_i);
		#1 por = 1'b0;
		ones = 8'h00;
		repeat (16)
		begin
			@(posedge clk_i);
			ones = ones + {7'h00, rco};
		end
		chk("rtc_clock_pin_o", 8'h08, ones);
		#1 reset_i = 1'b1;
		@(posedge clk_i);
		#1 reset_i = 1'b0;
		chk("mode after reset", 8'h00, {5'h00, rcoe, wroe, mdis});
		acc(1, MODE_ADDR, MODE_PAGE, 8'h00);
		chk("rtc_clock_pin_o", 8'h00, {7'h00, rco});
		$display("test mode done");
		// software clears every source after reset and never read-modify-writes
		acc(1, CFG_ADDR, CFG_PAGE, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			kick_src(i);
			repeat (4) @(posedge clk_i);
			acc(0, CFG_ADDR, CFG_PAGE, 8'h01 << i);
			acc(1, CFG_ADDR, CFG_PAGE, 8'h20);
		end
		$display("test flags done");
		acc(1, CFG_ADDR, CFG_PAGE, 8'h81);
		chk("sleep_o", 8'h01, {7'h00, slp});
		kick_src(0);
		wake_wait();
		chk("wake_request_pin_o", 8'h00, {7'h00, wrp});
		chk("lp_osc_keep_o", 8'h01, {7'h00, keep});
		acc(0, CFG_ADDR, CFG_PAGE, 8'h01);
		acc(1, CFG_ADDR, CFG_PAGE, 8'h80);
		chk("sleep_o", 8'h00, {7'h00, slp});
		acc(1, CFG_ADDR, CFG_PAGE, 8'h20);
		acc(0, CFG_ADDR, CFG_PAGE, 8'h00);
		$display("test sleep done");
		acc(1, CFG_ADDR, CFG_PAGE, 8'h44);
		chk("suspend_o", 8'h01, {7'h00, susp});
		kick_src(2);
		wake_wait();
		{re, addr, page} = {1'b1, CFG_ADDR, CFG_PAGE};
		exp_q.push_back(8'h00);
		@(posedge clk_i);
		#1 re = 1'b0;
		acc(0, CFG_ADDR, CFG_PAGE, 8'h04);
		acc(1, CFG_ADDR, CFG_PAGE, 8'h20);
		$display("test suspend done");
		acc(1, CFG_ADDR, CFG_PAGE, 8'h80);
		kick_src(5);
		wake_wait();
		acc(0, CFG_ADDR, CFG_PAGE, 8'h10);
		acc(1, CFG_ADDR, CFG_PAGE, 8'h20);
		$display("test reset pin done");
		acc(1, EXT_ADDR, 4'h0, 8'hFF);
		acc(1, CFG_ADDR, CFG_PAGE, 8'h80);
		chk("sleep_o", 8'h01, {7'h00, slp});
		kick_src(4);
		wake_wait();
		acc(0, EXT_ADDR, 4'h0, 8'h01);
		@(posedge clk_i);
		#1 $display("test cap sense done");
		close_out();
	end
endmodule : test_low_power_wakeup_control
`default_nettype wire
